// *** core/clc_regs.vh ***
// Purpose: Register map constants for the configuration lock control block
// Assumes: Included by the clc_ design files only
// Notes: Every offset, field position and reset value used in the logic lives here
//
// What this block does
// - Every bit of the lock control register reads zero after reset.
// - Bit 7 (lock hold) is write-one-to-set and only the standby power-up reset returns it to zero.
// - With the hold bit clear, main power-up, hardware and standby resets clear the governed locks; when set, only standby reset does.
// - The hold bit governs the pinmux, GPIO, fast-disable, clock, per-pin GPIO, extension bus, RAM, power-timer and sleep-encode locks.
// - Writing one to bit 6 clears the pin multiplexing lock.
// - Writing one to bit 5 clears the global GPIO lock and every per-pin GPIO lock.
// - Writing one to bit 4 clears the fast-disable lock.
// - Writing one to bit 3 clears the clock configuration lock.
// - Writing one to bit 2 clears the extension bus I/O map, memory map, zone and host-access locks.
// - Writing one to bit 1 clears every bit of the RAM lock register.
// - Writing one to bit 0 clears the power-timer reset lock and the sleep-state encoding lock.
// - Each unlock command bit acts as a one-shot and always reads back as zero.
// - Unlock commands clear their locks regardless of the hold bit.
`ifndef CLC_REGS_VH
`define CLC_REGS_VH

`define CLC_ADDR_W          8
`define CLC_DATA_W          8
`define CLC_CMD_W           7

`define CLC_LOCK_CTL_OFS    8'h02
`define CLC_LOCK_CTL_RST    8'h00
`define CLC_RD_IDLE         8'h00

`define CLC_BIT_HOLD        7
`define CLC_BIT_PINMUX      6
`define CLC_BIT_GPIO        5
`define CLC_BIT_FASTDIS     4
`define CLC_BIT_CLKCFG      3
`define CLC_BIT_EXTBUS      2
`define CLC_BIT_RAMLOCK     1
`define CLC_BIT_WAKECTL     0

`define CLC_CMD_LSB         0
`define CLC_CMD_MSB         6
`define CLC_CMD_IDLE        7'h00
`define CLC_CMD_RD_VAL      7'h00

`endif

// *** core/clc_unlock_pulse.v ***
// Purpose: One-shot unlock command strobes for the seven unlock bits
// Assumes: Write strobe is already decoded to the lock control offset
// Notes: Command bits hold no state, so nothing is left to read back
`include "clc_regs.vh"

module clc_unlock_pulse #(
    parameter CMD_W = `CLC_CMD_W
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst,
    // Decoded write
    input  wire             wr_hit,
    input  wire [CMD_W-1:0] wr_cmd,
    // Strobes
    output wire [CMD_W-1:0] pulse
);

    reg [CMD_W-1:0] pulse_q;

    genvar i;
    generate
        for (i = 0; i < CMD_W; i = i + 1)
        begin : g_cmd
            always @(posedge core_clk)
            begin
                if (rst)
                    pulse_q[i] <= 1'b0;
                else
                    pulse_q[i] <= wr_hit & wr_cmd[i];
            end
        end
    endgenerate

    assign pulse = pulse_q;

endmodule // clc_unlock_pulse

// *** core/clc_reset_sel.v ***
// Purpose: Lock hold bit and choice of which resets clear the governed locks
// Assumes: rst is the standby power-up reset; main_por and hw_rst are levels
// Notes: The hold bit lives on standby power, so main-side resets never touch it
module clc_reset_sel (
    // Clock and reset
    input  wire core_clk,
    input  wire rst,
    // Write of the hold bit
    input  wire wr_hit,
    input  wire wr_hold,
    // Main-side resets
    input  wire main_por,
    input  wire hw_rst,
    // State
    output wire lock_hold_standby,
    output wire reset_clr
);

    reg hold_q;
    reg hold_d;
    reg reset_clr_q;

    always @*
    begin
        hold_d = hold_q | (wr_hit & wr_hold);
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            hold_q      <= 1'b0;
            // Standby reset always clears everything
            reset_clr_q <= 1'b1;
        end
        else
        begin
            hold_q      <= hold_d;
            reset_clr_q <= (main_por | hw_rst) & ~hold_q;
        end
    end

    assign lock_hold_standby = hold_q;
    assign reset_clr         = reset_clr_q;

endmodule // clc_reset_sel

// *** core/clc_lock_ctrl.v ***
// Purpose: Standby-powered lock control register and clear strobes to lock owners
// Assumes: Serial management bus front end presents decoded byte reads and writes
// Notes: Lock bits live in their owning units; this block only tells them when to clear
`include "clc_regs.vh"

module clc_lock_ctrl #(
    parameter ADDR_W = `CLC_ADDR_W,
    parameter DATA_W = `CLC_DATA_W
) (
    // Clock and standby power-up reset
    input  wire              core_clk,
    input  wire              rst,
    // Main-side reset sources
    input  wire              main_por,
    input  wire              hw_rst,
    // Register access from the serial bus slave
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [DATA_W-1:0] reg_wdata,
    output wire [DATA_W-1:0] reg_rdata,
    output wire              reg_rvalid,
    // Hold state
    output wire              lock_hold_standby,
    // Clear strobes, multiplexing and GPIO
    output wire              pinmux_cfg_lock_clr,
    output wire              gpio_global_lock_clr,
    output wire              gpio_pin_lock_clr,
    // Clear strobes, fast disable and clock
    output wire              fastdis_lock_clr,
    output wire              clk_cfg_lock_clr,
    // Clear strobes, extension bus
    output wire              extbus_io_map_lock_clr,
    output wire              extbus_mem_map_lock_clr,
    output wire              extbus_zone_lock_clr,
    output wire              extbus_host_access_lock_clr,
    // Clear strobes, RAM lock register
    output wire              ram_lock_reg_clr,
    // Clear strobes, wake control unit
    output wire              power_timer_reset_lock_clr,
    output wire              sleep_encode_lock_clr
);

    // Address decode, shared by read and write paths
    function addr_is_lock_ctl;
        input [ADDR_W-1:0] addr;
        begin
            addr_is_lock_ctl = (addr == `CLC_LOCK_CTL_OFS);
        end
    endfunction

    wire                  wr_hit;
    wire                  rd_hit;
    wire [`CLC_CMD_W-1:0] unlock_pulse;
    wire                  reset_clr;
    wire                  hold;

    reg  [DATA_W-1:0]     rdata_q;
    reg  [DATA_W-1:0]     rdata_d;
    reg                   rvalid_q;

    assign wr_hit = reg_wr & addr_is_lock_ctl(reg_addr);
    assign rd_hit = reg_rd & addr_is_lock_ctl(reg_addr);

    clc_reset_sel u_reset_sel (
        .core_clk          (core_clk),
        .rst               (rst),
        .wr_hit            (wr_hit),
        .wr_hold           (reg_wdata[`CLC_BIT_HOLD]),
        .main_por          (main_por),
        .hw_rst            (hw_rst),
        .lock_hold_standby (hold),
        .reset_clr         (reset_clr)
    );

    clc_unlock_pulse #(
        .CMD_W (`CLC_CMD_W)
    ) u_unlock_pulse (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_hit   (wr_hit),
        .wr_cmd   (reg_wdata[`CLC_CMD_MSB:`CLC_CMD_LSB]),
        .pulse    (unlock_pulse)
    );

    // Read path; command bits never hold a value, unmapped reads give zero
    always @*
    begin
        rdata_d = `CLC_RD_IDLE;
        if (rd_hit)
        begin
            rdata_d = {hold, `CLC_CMD_RD_VAL};
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            rdata_q  <= `CLC_LOCK_CTL_RST;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata         = rdata_q;
    assign reg_rvalid        = rvalid_q;
    assign lock_hold_standby = hold;

    // Unlock strobes OR the reset clear; commands bypass the hold bit
    assign pinmux_cfg_lock_clr         = unlock_pulse[`CLC_BIT_PINMUX]  | reset_clr;
    assign gpio_global_lock_clr        = unlock_pulse[`CLC_BIT_GPIO]    | reset_clr;
    assign gpio_pin_lock_clr           = unlock_pulse[`CLC_BIT_GPIO]    | reset_clr;
    assign fastdis_lock_clr            = unlock_pulse[`CLC_BIT_FASTDIS] | reset_clr;
    assign clk_cfg_lock_clr            = unlock_pulse[`CLC_BIT_CLKCFG]  | reset_clr;
    assign extbus_io_map_lock_clr      = unlock_pulse[`CLC_BIT_EXTBUS]  | reset_clr;
    assign extbus_mem_map_lock_clr     = unlock_pulse[`CLC_BIT_EXTBUS]  | reset_clr;
    assign extbus_zone_lock_clr        = unlock_pulse[`CLC_BIT_EXTBUS]  | reset_clr;
    assign extbus_host_access_lock_clr = unlock_pulse[`CLC_BIT_EXTBUS]  | reset_clr;
    assign ram_lock_reg_clr            = unlock_pulse[`CLC_BIT_RAMLOCK] | reset_clr;
    assign power_timer_reset_lock_clr  = unlock_pulse[`CLC_BIT_WAKECTL] | reset_clr;
    assign sleep_encode_lock_clr       = unlock_pulse[`CLC_BIT_WAKECTL] | reset_clr;

endmodule // clc_lock_ctrl

// *** testbench/clc_lock_props.sv ***
// Purpose: Port assertions for the lock control block
// Assumes: Bound onto clc_lock_ctrl
// Notes: Strobes are judged one cycle after their cause
module clc_lock_props (
    input wire logic       core_clk, rst, main_por, hw_rst, reg_wr, reg_rd, reg_rvalid, lock_hold_standby,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic       pinmux_cfg_lock_clr, gpio_global_lock_clr, gpio_pin_lock_clr, fastdis_lock_clr,
    input wire logic       clk_cfg_lock_clr, extbus_io_map_lock_clr, extbus_mem_map_lock_clr,
    input wire logic       extbus_zone_lock_clr, extbus_host_access_lock_clr, ram_lock_reg_clr,
    input wire logic       power_timer_reset_lock_clr, sleep_encode_lock_clr
);
    timeunit 1ns;
    timeprecision 1ns;
    wire w2   = reg_wr && reg_addr == 8'h02;
    wire mclr = (main_por || hw_rst) && !lock_hold_standby;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cmd(int b);
        w2 && reg_wdata[b];
    endsequence
    sequence s_once;
        w2 && reg_wdata[3] ##1 !(w2 && reg_wdata[3]) && !mclr;
    endsequence
    a_pinmux_clr: assert property (s_cmd(6) |=> pinmux_cfg_lock_clr) else $error("pinmux clear missing");
    a_gpio_clr: assert property (s_cmd(5) |=> gpio_global_lock_clr && gpio_pin_lock_clr)
        else $error("gpio clear missing");
    a_fastdis_clr: assert property (s_cmd(4) |=> fastdis_lock_clr) else $error("fastdis clear missing");
    a_clkcfg_clr: assert property (s_cmd(3) |=> clk_cfg_lock_clr) else $error("clock clear missing");
    a_extbus_clr: assert property (s_cmd(2) |=> extbus_io_map_lock_clr && extbus_mem_map_lock_clr
        && extbus_zone_lock_clr && extbus_host_access_lock_clr) else $error("extbus clear missing");
    a_ram_clr: assert property (s_cmd(1) |=> ram_lock_reg_clr) else $error("ram clear missing");
    a_wake_clr: assert property (s_cmd(0) |=> power_timer_reset_lock_clr && sleep_encode_lock_clr)
        else $error("wake clear missing");
    a_hold_set: assert property (s_cmd(7) |=> lock_hold_standby) else $error("hold not set");
    a_hold_sticky: assert property (lock_hold_standby |=> lock_hold_standby) else $error("hold lost");
    a_main_clr: assert property (mclr |=> pinmux_cfg_lock_clr && ram_lock_reg_clr && sleep_encode_lock_clr)
        else $error("main reset clear missing");
    a_no_stray: assert property (!(w2 && reg_wdata[6]) && !mclr |=> !pinmux_cfg_lock_clr)
        else $error("stray pinmux clear");
    a_pulse_once: assert property (s_once |=> !clk_cfg_lock_clr) else $error("clock clear too long");
    a_read_zero: assert property (reg_rd |=> reg_rvalid && reg_rdata[6:0] == 7'h00)
        else $error("command bits read nonzero");
    a_reset_val: assert property (disable iff (1'b0) rst |=> !lock_hold_standby && reg_rdata == 8'h00)
        else $error("reset value wrong");
endmodule // clc_lock_props

bind clc_lock_ctrl clc_lock_props chk_u (.*);

// *** testbench/clc_ec_model.sv ***
// Purpose: Embedded controller stand-in on the register bus
// Assumes: put is called just after a falling edge
// Notes: Idle address and data carry noise, never the last value
module clc_ec_model (
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    task put(input logic w, r, input logic [7:0] a, d, input logic [15:0] n);
        reg_wr    = w;
        reg_rd    = r;
        reg_addr  = (w || r) ? a : n[15:8];
        reg_wdata = w ? d : n[7:0];
    endtask
endmodule // clc_ec_model

// *** testbench/clc_lock_ctrl_tb.sv ***
// Purpose: Self-checking bench for clc_lock_ctrl
// Assumes: Inputs change on the falling edge
// Notes: Expectations queue per cycle, checked 1 ns after each rise
module clc_lock_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic            core_clk = 1'b0, rst = 1'b1, main_por = 1'b0, hw_rst = 1'b0, h = 1'b0;
    wire logic       reg_wr, reg_rd, reg_rvalid, hold;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
    wire logic [11:0] clr;
    integer          seed = 32'h67f8e25d, fails = 0, total_checks = 0, cyc = 0;
    logic [31:0]     rn;
    logic [13:0]     oq[$];
    logic [7:0]      rq[$];
    logic [11:0]     m[7] = '{12'h003, 12'h004, 12'h078, 12'h080, 12'h100, 12'h600, 12'h800};
    clc_lock_ctrl dut_u (.core_clk(core_clk), .rst(rst), .main_por(main_por), .hw_rst(hw_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .lock_hold_standby(hold), .pinmux_cfg_lock_clr(clr[11]),
        .gpio_global_lock_clr(clr[10]), .gpio_pin_lock_clr(clr[9]), .fastdis_lock_clr(clr[8]),
        .clk_cfg_lock_clr(clr[7]), .extbus_io_map_lock_clr(clr[6]), .extbus_mem_map_lock_clr(clr[5]),
        .extbus_zone_lock_clr(clr[4]), .extbus_host_access_lock_clr(clr[3]), .ram_lock_reg_clr(clr[2]),
        .power_timer_reset_lock_clr(clr[1]), .sleep_encode_lock_clr(clr[0]));
    clc_ec_model ec_u (.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    always #25 core_clk = ~core_clk;
    task close_out;
        if (cyc >= 3000) fails++;
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [13:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Clears and read data see the hold value before a same-cycle set
    task step(input logic w, r, input logic [7:0] a, d, input logic s, p, x);
        logic [11:0] e;
        logic [31:0] n;
        @(negedge core_clk);
        n = $random(seed);
        ec_u.put(w, r, a, d, n[15:0]);
        rst = s; main_por = p; hw_rst = x;
        e = ((p || x) && !h) ? 12'hFFF : 12'h000;
        for (int i = 0; i < 7; i++) if (w && a == 8'h02 && d[i]) e |= m[i];
        if (r && !s) rq.push_back(a == 8'h02 ? {h, 7'h00} : 8'h00);
        if (w && a == 8'h02 && d[7]) h = 1'b1;
        e = s ? 12'hFFF : e;
        h = s ? 1'b0 : h;
        oq.push_back({r && !s, h, e});
    endtask
    always @(posedge core_clk)
    begin
        #1;
        if (oq.size() > 0)
            chk({reg_rvalid, hold, clr}, oq.pop_front());
        if (reg_rvalid === 1'b1 && rq.size() > 0) chk({6'h00, reg_rdata}, {6'h00, rq.pop_front()});
    end
    always @(posedge core_clk) if (++cyc == 3000) close_out();
    task rnd_run;
        repeat (40)
        begin
            rn = $random(seed);
            step(rn[8], rn[9], rn[10] ? 8'h02 : rn[23:16], rn[7:0], 0, rn[11], rn[12]);
        end
    endtask
    initial
    begin
        repeat (3) step(0, 0, 8'h00, 8'h00, 1, 0, 0);
        step(0, 0, 8'h00, 8'h00, 0, 0, 0);
        step(0, 1, 8'h02, 8'h00, 0, 0, 0);
        for (int i = 0; i < 7; i++) step(1, 0, 8'h02, 8'h01 << i, 0, 0, 0);
        step(1, 0, 8'h02, 8'h00, 0, 0, 0);
        step(1, 0, 8'h03, 8'h7F, 0, 0, 0);
        step(0, 0, 8'h00, 8'h00, 0, 1, 0);
        step(0, 0, 8'h00, 8'h00, 0, 0, 1);
        step(1, 0, 8'h02, 8'h80, 0, 1, 0);
        step(1, 0, 8'h02, 8'h00, 0, 0, 0);
        step(0, 1, 8'h02, 8'h00, 0, 1, 1);
        rnd_run();
        step(0, 0, 8'h00, 8'h00, 1, 0, 0);
        step(0, 0, 8'h00, 8'h00, 0, 0, 0);
        step(0, 1, 8'h02, 8'h00, 0, 1, 0);
        rnd_run();
        repeat (2) step(0, 0, 8'h00, 8'h00, 0, 0, 0);
        // Let the last queued note be compared before the verdict
        @(posedge core_clk);
        #2;
        close_out();
    end
endmodule // clc_lock_ctrl_tb
